//--- core/rfcfg_regs.sv
// Purpose: register slice 1Ch to 25h of a contactless reader front end
// Assumes: host interface decoded elsewhere into a one-cycle write or read strobe with address
// Notes: read data registered one cycle after the strobe; all outputs from flip-flops
`timescale 1ns/100ps
module rfcfg_regs (
	input  wire logic       CLK,
	input  wire logic       RESETN,
	input  wire logic [5:0] ADDR,
	input  wire logic       WR_EN,
	input  wire logic       RD_EN,
	input  wire logic [7:0] WDATA,
	output logic      [7:0] RDATA,
	output logic            RD_VALID,
	input  wire logic       CRC_DONE,
	input  wire logic [15:0] CRC_VALUE,
	input  wire logic       CARRIER_TICK,
	input  wire logic       MOD_START,
	output logic            MOD_PULSE,
	input  wire logic       RX_BIT,
	input  wire logic       RX_BIT_VALID,
	input  wire logic       RX_BIT_IS_PARITY,
	output logic            RX_DATA_BIT,
	output logic            RX_DATA_VALID,
	output logic            PARITY_GEN_EN,
	output logic            PARITY_CHECK_EN,
	output logic      [3:0] EXTRA_RESPONSE_TIME,
	output logic      [2:0] BAUD_FACTOR_HI,
	output logic      [4:0] BAUD_FACTOR_LO,
	output logic      [7:0] MILLER_PULSE_WIDTH
);
	typedef struct packed {
		logic [7:0] tx_param;
		logic [7:0] rx_param;
		logic [7:0] uart_speed;
		logic [7:0] crc_high;
		logic [7:0] crc_low;
		logic [7:0] pulse_width;
		logic [7:0] rdata;
		logic       rd_valid;
		logic       rx_bit;
		logic       rx_valid;
		logic [3:0] ert;
		logic       par_en;
	} rfcfg_st_t;
	rfcfg_st_t s_q, s_d;
	logic       pulse_raw;
	logic [7:0] rd_mux;
	localparam int ERT_W = rfcfg_pkg::ERT_W;

	// -----------------------------
	// read mux
	// -----------------------------
	always_comb begin
		unique case (ADDR)
			rfcfg_pkg::ADDR_TX_PARAM:   rd_mux = s_q.tx_param;
			rfcfg_pkg::ADDR_RX_PARAM:   rd_mux = s_q.rx_param;
			rfcfg_pkg::ADDR_RSVD_1E:    rd_mux = rfcfg_pkg::RST_RSVD_1E;
			rfcfg_pkg::ADDR_UART_SPEED: rd_mux = s_q.uart_speed;
			rfcfg_pkg::ADDR_RSVD_20:    rd_mux = rfcfg_pkg::RST_RSVD_20;
			rfcfg_pkg::ADDR_CRC_HIGH:   rd_mux = s_q.crc_high;
			rfcfg_pkg::ADDR_CRC_LOW:    rd_mux = s_q.crc_low;
			rfcfg_pkg::ADDR_RSVD_23:    rd_mux = rfcfg_pkg::RST_RSVD_23;
			rfcfg_pkg::ADDR_PULSE_W:    rd_mux = s_q.pulse_width;
			rfcfg_pkg::ADDR_RSVD_25:    rd_mux = rfcfg_pkg::RST_RSVD_25;
			default:                    rd_mux = 8'h00;
		endcase
	end

	// -----------------------------
	// next state
	// -----------------------------
	always_comb begin
		s_d = s_q;
		s_d.rd_valid = RD_EN;
		if (RD_EN) begin
			s_d.rdata = rd_mux;
		end
		if (WR_EN) begin
			unique case (ADDR)
				rfcfg_pkg::ADDR_TX_PARAM: s_d.tx_param = (s_q.tx_param & ~rfcfg_pkg::TX_WRITE_MASK) |
					(WDATA & rfcfg_pkg::TX_WRITE_MASK);
				rfcfg_pkg::ADDR_RX_PARAM: s_d.rx_param = (s_q.rx_param & ~rfcfg_pkg::RX_WRITE_MASK) |
					(WDATA & rfcfg_pkg::RX_WRITE_MASK);
				rfcfg_pkg::ADDR_UART_SPEED: s_d.uart_speed = WDATA;
				rfcfg_pkg::ADDR_PULSE_W:    s_d.pulse_width = WDATA;
				default: ;
			endcase
		end
		if (CRC_DONE) begin
			s_d.crc_high = CRC_VALUE[15:8];
			s_d.crc_low  = CRC_VALUE[7:0];
		end
		s_d.ert = ERT_W'(s_q.tx_param[1:0]) + ERT_W'(rfcfg_pkg::EXTRA_RESP_DEF);
		s_d.par_en = !s_q.rx_param[rfcfg_pkg::PARITY_OFF_BIT];
		s_d.rx_valid = RX_BIT_VALID && (!RX_BIT_IS_PARITY || s_q.rx_param[rfcfg_pkg::PARITY_OFF_BIT]);
		s_d.rx_bit   = RX_BIT;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_q             <= '0;
			s_q.tx_param    <= rfcfg_pkg::RST_TX_PARAM;
			s_q.rx_param    <= rfcfg_pkg::RST_RX_PARAM;
			s_q.uart_speed  <= rfcfg_pkg::RST_UART_SPEED;
			s_q.crc_high    <= rfcfg_pkg::RST_CRC;
			s_q.crc_low     <= rfcfg_pkg::RST_CRC;
			s_q.pulse_width <= rfcfg_pkg::RST_PULSE_W;
			s_q.ert         <= ERT_W'(rfcfg_pkg::RST_TX_PARAM[1:0]) + ERT_W'(rfcfg_pkg::EXTRA_RESP_DEF);
			s_q.par_en      <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// -----------------------------
	// miller pulse
	// -----------------------------
	// width from 24h
	rfcfg_pulse #(
		.W(8)
	) u_pulse (
		.clk   (CLK),
		.resetn(RESETN),
		.start (MOD_START),
		.tick  (CARRIER_TICK),
		.width (s_q.pulse_width),
		.pulse (pulse_raw)
	);

	logic mod_pulse_q;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mod_pulse_q <= 1'b0;
		end else begin
			mod_pulse_q <= pulse_raw;
		end
	end

	// -----------------------------
	// outputs
	// -----------------------------
	assign RDATA               = s_q.rdata;
	assign RD_VALID            = s_q.rd_valid;
	assign MOD_PULSE           = mod_pulse_q;
	assign RX_DATA_BIT         = s_q.rx_bit;
	assign RX_DATA_VALID       = s_q.rx_valid;
	assign PARITY_GEN_EN       = s_q.par_en;
	assign PARITY_CHECK_EN     = s_q.par_en;
	assign EXTRA_RESPONSE_TIME = s_q.ert;
	assign BAUD_FACTOR_HI      = s_q.uart_speed[rfcfg_pkg::BAUD_HI_LSB+rfcfg_pkg::BAUD_HI_W-1:rfcfg_pkg::BAUD_HI_LSB];
	assign BAUD_FACTOR_LO      = s_q.uart_speed[rfcfg_pkg::BAUD_HI_LSB-1:0];
	assign MILLER_PULSE_WIDTH  = s_q.pulse_width;

	// -----------------------------
	// checks
	// -----------------------------
	property p_ert;
		@(posedge CLK) disable iff (!RESETN)
		##1 EXTRA_RESPONSE_TIME == ERT_W'($past(s_q.tx_param[1:0])) + ERT_W'(rfcfg_pkg::EXTRA_RESP_DEF);
	endproperty
	a_ert: assert property (p_ert) else $error("extra response time wrong");

	property p_parity;
		@(posedge CLK) disable iff (!RESETN)
		s_q.rx_param[rfcfg_pkg::PARITY_OFF_BIT] |=> !PARITY_GEN_EN && !PARITY_CHECK_EN;
	endproperty
	a_parity: assert property (p_parity) else $error("parity not off");

	property p_par_pass;
		@(posedge CLK) disable iff (!RESETN)
		(RX_BIT_VALID && RX_BIT_IS_PARITY && s_q.rx_param[rfcfg_pkg::PARITY_OFF_BIT]) |=> RX_DATA_VALID;
	endproperty
	a_par_pass: assert property (p_par_pass) else $error("parity bit dropped");

	property p_crc_hi;
		@(posedge CLK) disable iff (!RESETN)
		(RD_EN && ADDR == rfcfg_pkg::ADDR_CRC_HIGH && !CRC_DONE) |=> RDATA == s_q.crc_high;
	endproperty
	a_crc_hi: assert property (p_crc_hi) else $error("crc high read wrong");

	property p_crc_hi_cap;
		@(posedge CLK) disable iff (!RESETN)
		CRC_DONE |=> s_q.crc_high == $past(CRC_VALUE[15:8]);
	endproperty
	a_crc_hi_cap: assert property (p_crc_hi_cap) else $error("crc high not captured");

	property p_crc_lo;
		@(posedge CLK) disable iff (!RESETN)
		CRC_DONE |=> s_q.crc_low == $past(CRC_VALUE[7:0]);
	endproperty
	a_crc_lo: assert property (p_crc_lo) else $error("crc low not captured");

	property p_baud;
		@(posedge CLK) disable iff (!RESETN)
		(WR_EN && ADDR == rfcfg_pkg::ADDR_UART_SPEED) |=> {BAUD_FACTOR_HI, BAUD_FACTOR_LO} == $past(WDATA);
	endproperty
	a_baud: assert property (p_baud) else $error("baud factors not written");

	property p_rsvd;
		@(posedge CLK) disable iff (!RESETN)
		(RD_EN && ADDR == rfcfg_pkg::ADDR_RSVD_25) |=> RDATA == rfcfg_pkg::RST_RSVD_25;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved read wrong");

	property p_rx_mask;
		@(posedge CLK) disable iff (!RESETN)
		##1 s_q.rx_param[7:5] == 3'h0 && s_q.rx_param[3:0] == 4'h0 && s_q.tx_param[7:2] == 6'h18;
	endproperty
	a_rx_mask: assert property (p_rx_mask) else $error("reserved bits changed");

	property p_rst;
		@(posedge CLK) $rose(RESETN) |-> MILLER_PULSE_WIDTH == rfcfg_pkg::RST_PULSE_W || WR_EN;
	endproperty
	a_rst: assert property (p_rst) else $error("pulse width reset wrong");
endmodule

//--- core/rfcfg_pkg.sv
// Purpose: constants for the reader frame configuration register slice
// Assumes: 8-bit registers on a 6-bit internal register address
// Notes: one clock, asynchronous active-low reset
package rfcfg_pkg;
	// -----------------------------
	// addresses
	// -----------------------------
	localparam logic [5:0] ADDR_TX_PARAM   = 6'h1c;
	localparam logic [5:0] ADDR_RX_PARAM   = 6'h1d;
	localparam logic [5:0] ADDR_RSVD_1E    = 6'h1e;
	localparam logic [5:0] ADDR_UART_SPEED = 6'h1f;
	localparam logic [5:0] ADDR_RSVD_20    = 6'h20;
	localparam logic [5:0] ADDR_CRC_HIGH   = 6'h21;
	localparam logic [5:0] ADDR_CRC_LOW    = 6'h22;
	localparam logic [5:0] ADDR_RSVD_23    = 6'h23;
	localparam logic [5:0] ADDR_PULSE_W    = 6'h24;
	localparam logic [5:0] ADDR_RSVD_25    = 6'h25;
	// -----------------------------
	// reset values
	// -----------------------------
	localparam logic [7:0] RST_TX_PARAM   = 8'h62;
	localparam logic [7:0] RST_RX_PARAM   = 8'h00;
	localparam logic [7:0] RST_RSVD_1E    = 8'h00;
	localparam logic [7:0] RST_UART_SPEED = 8'heb;
	localparam logic [7:0] RST_RSVD_20    = 8'h00;
	localparam logic [7:0] RST_CRC        = 8'hff;
	localparam logic [7:0] RST_RSVD_23    = 8'h88;
	localparam logic [7:0] RST_PULSE_W    = 8'h26;
	localparam logic [7:0] RST_RSVD_25    = 8'h87;
	// -----------------------------
	// fields
	// -----------------------------
	localparam logic [7:0] TX_WRITE_MASK  = 8'h03;
	localparam logic [7:0] RX_WRITE_MASK  = 8'h10;
	localparam int         PARITY_OFF_BIT = 4;
	localparam int         BAUD_HI_LSB    = 5;
	localparam int         BAUD_HI_W      = 3;
	localparam int         BAUD_LO_W      = 5;
	localparam logic [2:0] EXTRA_RESP_DEF = 3'h7;
	localparam int         ERT_W          = 4;
endpackage

//--- core/rfcfg_pulse.sv
// Purpose: Miller pulse timer for the configuration slice
// Assumes: one start pulse per modulation pause, carrier tick as clock enable input
// Notes: pulse spans width plus one carrier ticks
`timescale 1ns/100ps
module rfcfg_pulse #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         start,
	input  wire logic         tick,
	input  wire logic [W-1:0] width,
	output logic              pulse
);
	typedef struct packed {
		logic         act;
		logic [W-1:0] cnt;
	} rfcfg_pst_t;
	rfcfg_pst_t s_q, s_d;

	// -----------------------------
	// counter
	// -----------------------------
	always_comb begin
		s_d = s_q;
		if (start) begin
			s_d.act = 1'b1;
			s_d.cnt = width;
		end else if (s_q.act && tick) begin
			if (s_q.cnt == '0) begin
				s_d.act = 1'b0;
			end else begin
				s_d.cnt = s_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pulse = s_q.act;

	property p_pulse_ends;
		@(posedge clk) disable iff (!resetn)
		(s_q.act && tick && s_q.cnt == '0 && !start) |=> !s_q.act;
	endproperty
	a_pulse_ends: assert property (p_pulse_ends) else $error("pulse outlived its width");
endmodule

//--- sim/rfcfg_host.sv
// Purpose: host model driving the register strobes
// Assumes: one access per call, moves 1 ns after the edge
// Notes: released lines show inverted values, never the last one
`timescale 1ns/100ps
module rfcfg_host (
	input  wire logic       clk,
	input  wire logic       rd_valid,
	input  wire logic [7:0] rdata,
	output logic      [5:0] addr,
	output logic            wr_en,
	output logic            rd_en,
	output logic      [7:0] wdata
);
	initial begin
		addr = 6'h3f;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = 8'h00;
	end
	// callers keep width under half a bit
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	// crc bytes read at their reset value and again after done seen
	task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk);
		#1;
		addr = a;
		rd_en = 1'b1;
		@(posedge clk);
		#1;
		rd_en = 1'b0;
		addr = ~a;
		ok = rd_valid;
		d = rdata;
	endtask
endmodule

//--- sim/reader_frame_config_regs_tb.sv
// Purpose: self-checking bench for the register slice
// Assumes: carrier tick held high during the pulse test
// Notes: rows give reset value, write data and readback
`timescale 1ns/100ps
module reader_frame_config_regs_tb;
	typedef struct packed {
		logic [5:0] a;
		logic [7:0] rst;
		logic [7:0] wd;
		logic [7:0] rb;
	} rfcfg_row_t;
	logic clk = 1'b0, resetn = 1'b0, crc_done = 1'b0, tick = 1'b0, mod_start = 1'b0;
	logic rx_bit = 1'b0, rx_vld = 1'b0, rx_par = 1'b0;
	logic [15:0] crc_value = 16'h0000;
	logic [5:0] addr;
	logic wr_en, rd_en, rd_valid, mod_pulse, rx_dbit, rx_dvld, par_gen, par_chk, ok;
	logic [7:0] wdata, rdata, pw, d;
	logic [3:0] ert;
	logic [2:0] bhi;
	logic [4:0] blo;
	int n_fail = 0, comparisons = 0, cyc = 0, hi;
	rfcfg_row_t rows [11] = '{'{6'h1c, 8'h62, 8'hff, 8'h63}, '{6'h1d, 8'h00, 8'hff, 8'h10},
		'{6'h1e, 8'h00, 8'hff, 8'h00}, '{6'h1f, 8'heb, 8'h5a, 8'h5a}, '{6'h20, 8'h00, 8'hff, 8'h00},
		'{6'h21, 8'hff, 8'h00, 8'hff}, '{6'h22, 8'hff, 8'h00, 8'hff}, '{6'h23, 8'h88, 8'hff, 8'h88},
		'{6'h24, 8'h26, 8'h02, 8'h02}, '{6'h25, 8'h87, 8'hff, 8'h87}, '{6'h00, 8'h00, 8'hff, 8'h00}};
	always #2 clk = ~clk;
	rfcfg_host i_host (.clk(clk), .rd_valid(rd_valid), .rdata(rdata), .addr(addr), .wr_en(wr_en),
		.rd_en(rd_en), .wdata(wdata));
	rfcfg_regs i_dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
		.WDATA(wdata), .RDATA(rdata), .RD_VALID(rd_valid), .CRC_DONE(crc_done), .CRC_VALUE(crc_value),
		.CARRIER_TICK(tick), .MOD_START(mod_start), .MOD_PULSE(mod_pulse), .RX_BIT(rx_bit),
		.RX_BIT_VALID(rx_vld), .RX_BIT_IS_PARITY(rx_par), .RX_DATA_BIT(rx_dbit), .RX_DATA_VALID(rx_dvld),
		.PARITY_GEN_EN(par_gen), .PARITY_CHECK_EN(par_chk), .EXTRA_RESPONSE_TIME(ert),
		.BAUD_FACTOR_HI(bhi), .BAUD_FACTOR_LO(blo), .MILLER_PULSE_WIDTH(pw));
	// --------------------
	// checks
	// --------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
		i_host.rd(a, d, ok);
		chk("read valid", 8'h01, {7'h00, ok});
		chk("read data", e, d);
	endtask
	task automatic chk_out(input logic [7:0] e_ert, e_hi, e_lo, e_par);
		chk("response time", e_ert, {4'h0, ert});
		chk("baud hi", e_hi, {5'h00, bhi});
		chk("baud lo", e_lo, {3'h0, blo});
		chk("parity enables", e_par, {6'h00, par_gen, par_chk});
	endtask
	// parity bits vanish unless parity is off
	task automatic rx_send(input logic b, input logic par, input logic ev);
		@(posedge clk);
		#1;
		rx_bit = b;
		rx_par = par;
		rx_vld = 1'b1;
		@(posedge clk);
		#1;
		rx_vld = 1'b0;
		rx_bit = ~b;
		chk("rx out", {6'h00, ev, ev & b}, {6'h00, rx_dvld, rx_dvld & rx_dbit});
	endtask
	task automatic stop_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			stop_test();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		#1;
		resetn = 1'b1;
		chk_out(8'h09, 8'h07, 8'h0b, 8'h03);
		chk("pulse width", 8'h26, pw);
		for (int i = 0; i < 11; i++) begin
			chk_rd(rows[i].a, rows[i].rst);
		end
		for (int i = 0; i < 11; i++) begin
			i_host.wr(rows[i].a, rows[i].wd);
			chk_rd(rows[i].a, rows[i].rb);
		end
		chk_out(8'h0a, 8'h02, 8'h1a, 8'h00);
		chk("pulse width", 8'h02, pw);
		rx_send(1'b1, 1'b1, 1'b1);
		rx_send(1'b0, 1'b1, 1'b1);
		i_host.wr(rfcfg_pkg::ADDR_RX_PARAM, 8'h00);
		rx_send(1'b1, 1'b1, 1'b0);
		rx_send(1'b1, 1'b0, 1'b1);
		// crc bytes taken while done is high only
		@(posedge clk);
		#1;
		crc_value = 16'hbeef;
		crc_done = 1'b1;
		@(posedge clk);
		#1;
		crc_done = 1'b0;
		crc_value = 16'h4110;
		chk_rd(rfcfg_pkg::ADDR_CRC_HIGH, 8'hbe);
		chk_rd(rfcfg_pkg::ADDR_CRC_LOW, 8'hef);
		// width 2 with a tick every clock gives three clocks
		tick = 1'b1;
		mod_start = 1'b1;
		@(posedge clk);
		#1;
		mod_start = 1'b0;
		hi = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (mod_pulse === 1'b1) hi++;
		end
		chk("pulse length", 8'h03, hi[7:0]);
		resetn = 1'b0;
		@(posedge clk);
		#1;
		resetn = 1'b1;
		chk_rd(rfcfg_pkg::ADDR_UART_SPEED, 8'heb);
		chk_out(8'h09, 8'h07, 8'h0b, 8'h03);
		chk("pulse width", 8'h26, pw);
		stop_test();
	end
endmodule
